// ### hdl/ssc_pkg.sv
// shared constants for the sensor sample and i/o control block
package ssc_pkg;

	// ************************************************************
	// frame layout: bit 15 write flag, [14:8] address, [7:0] data
	// ************************************************************
	localparam int FRAME_WR_BIT = 15;
	localparam logic [6:0] ADDR_PIN_IO = 7'h32;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_SAMPLE_PERIOD = 7'h36;
	localparam logic [6:0] ADDR_FILTER_RANGE = 7'h38;
	localparam logic [6:0] ADDR_SLEEP = 7'h3A;
	localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h3E;

	// ************************************************************
	// reset values and field positions
	// ************************************************************
	localparam logic [15:0] RST_SAMPLE_PERIOD = 16'h0001;
	localparam logic [15:0] RST_FILTER_RANGE = 16'h0402;
	localparam logic [15:0] RST_PIN_IO = 16'h0000;
	localparam logic [15:0] RST_MISC = 16'h0006;
	localparam logic [7:0] LOW_POWER_MIN = 8'h0A;
	localparam int SP_TIMEBASE_BIT = 7;
	localparam int GCMD_SW_RESET_BIT = 7;
	localparam int MISC_MEM_TEST_BIT = 11;
	localparam int MISC_SELF_TEST_BIT = 10;
	localparam int MISC_DR_EN_BIT = 2;
	localparam int MISC_DR_POL_BIT = 1;
	localparam int MISC_DR_SEL_BIT = 0;
	localparam logic [2:0] RANGE_MID = 3'b010;
	localparam logic [2:0] RANGE_NARROW = 3'b001;
	localparam logic [2:0] TAPS_MIN_MID = 3'h2;
	localparam logic [2:0] TAPS_MIN_NARROW = 3'h4;

	// ************************************************************
	// timing: times in ns, cycle counts derived from the clock
	// ************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int BASE_FAST_NS = 610350;
	localparam int BASE_SLOW_NS = 18921000;
	localparam int SLEEP_UNIT_NS = 500000000;
	localparam int DR_PULSE_NS = 150000;
	localparam int BASE_FAST_CYCLES = BASE_FAST_NS / CLK_PERIOD_NS;
	localparam int BASE_SLOW_CYCLES = BASE_SLOW_NS / CLK_PERIOD_NS;
	localparam int SLEEP_UNIT_CYCLES = SLEEP_UNIT_NS / CLK_PERIOD_NS;
	localparam int DR_PULSE_CYCLES = (DR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SSC_RUN = 2'b00,
		SSC_SLEEP_INDEF = 2'b01,
		SSC_SLEEP_TIMED = 2'b10
	} ssc_state_e;

endpackage

// ### hdl/ssc_core.sv
// sample timing, sleep, filter, i/o line and control register logic
// How it works
// - period equals base period times increment plus one
// - timebase bit picks slow or fast base
// - sample period resets to one, 819.2 SPS
// - period 0x0A or above selects low power
// - indefinite sleep until chip-select falls or reset
// - nonzero sleep byte sleeps count half-seconds
// - two cascaded averagers of two-power taps
// - range field selects gyro range, resets widest
// - middle range taps >= 2, narrow >= 4
// - line ownership: misc, then alarm, then gpio
// - direction bits set output, reset input
// - level bits drive outputs, read back inputs
// - external sampling: line four input, period zero
// - data ready defaults on, high, line one
// - data ready pulse between 100 and 200 us
// - misc bits enable, polarity, line select
// - memory test bit self-clears when done
// - self-test bit self-clears when done
// - manual stimulus bits follow host only
// - bias compensation and origin alignment enables
// - software reset reloads stored copies, restarts
module ssc_core import ssc_pkg::*; #(
	parameter int DATA_W = 16,
	parameter int FAST_CYCLES = BASE_FAST_CYCLES,
	parameter int SLOW_CYCLES = BASE_SLOW_CYCLES,
	parameter int HALF_SEC_CYCLES = SLEEP_UNIT_CYCLES,
	parameter int PULSE_CYCLES = DR_PULSE_CYCLES
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// register frames
	input wire logic frame_valid_in,
	input wire logic [15:0] frame_in,
	input wire logic cs_n_in,
	output logic rd_valid_out,
	output logic [15:0] rd_data_out,
	// stored copies reloaded on software reset
	input wire logic [15:0] nv_sample_period_in,
	input wire logic [15:0] nv_filter_range_in,
	input wire logic [15:0] nv_pin_io_in,
	input wire logic [15:0] nv_misc_in,
	// sensor data
	input wire logic [DATA_W-1:0] sample_data_in,
	output logic sample_tick_out,
	output logic [DATA_W-1:0] filtered_out,
	// alarm logic claims of the i/o lines
	input wire logic [3:0] alarm_own_in,
	input wire logic [3:0] alarm_level_in,
	// i/o lines
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n_out,
	// test engines and sensor controls
	input wire logic mem_test_done_in,
	input wire logic self_test_done_in,
	output logic mem_test_out,
	output logic self_test_out,
	output logic stim_neg_out,
	output logic stim_pos_out,
	output logic bias_comp_out,
	output logic origin_align_out,
	output logic [2:0] range_out,
	output logic low_power_out,
	output logic sleeping_out,
	output logic restart_out
);

	// ************************************************************
	// frame decode
	// ************************************************************
	localparam logic [19:0] FAST_M1 = 20'(FAST_CYCLES - 1);
	localparam logic [19:0] SLOW_M1 = 20'(SLOW_CYCLES - 1);
	localparam logic [24:0] HALF_M1 = 25'(HALF_SEC_CYCLES - 1);
	localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYCLES);
	localparam int SW = DATA_W + 7;

	logic wr;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic sw_reset;
	assign wr = frame_valid_in & frame_in[FRAME_WR_BIT];
	assign addr = frame_in[14:8];
	assign wdata = frame_in[7:0];
	assign sw_reset = wr && addr == ADDR_GLOBAL_CMD && wdata[GCMD_SW_RESET_BIT];

	function automatic logic [2:0] taps_floor(input logic [2:0] range, input logic [2:0] taps);
		logic [2:0] lim;
		lim = 3'h0;
		if (range == RANGE_MID)
			lim = TAPS_MIN_MID;
		else if (range == RANGE_NARROW)
			lim = TAPS_MIN_NARROW;
		taps_floor = (taps < lim) ? lim : taps;
	endfunction

	// ************************************************************
	// control registers
	// ************************************************************
	logic [7:0] sample_period;
	logic [8:0] sleep_control;
	logic [2:0] range;
	logic [2:0] taps;
	logic [3:0] pin_dir;
	logic [3:0] pin_level;
	logic [11:0] misc_control;
	ssc_state_e state;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			sample_period <= RST_SAMPLE_PERIOD[7:0];
		else if (sw_reset)
			sample_period <= nv_sample_period_in[7:0];
		else if (wr && addr == ADDR_SAMPLE_PERIOD)
			sample_period <= wdata;
	end

	// the range write bumps taps up; a later tap write may raise them further
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			range <= RST_FILTER_RANGE[10:8];
			taps <= RST_FILTER_RANGE[2:0];
		end else if (sw_reset) begin
			range <= nv_filter_range_in[10:8];
			taps <= taps_floor(nv_filter_range_in[10:8], nv_filter_range_in[2:0]);
		end else if (wr && addr == (ADDR_FILTER_RANGE | 7'h01)) begin
			range <= wdata[2:0];
			taps <= taps_floor(wdata[2:0], taps);
		end else if (wr && addr == ADDR_FILTER_RANGE)
			taps <= taps_floor(range, wdata[2:0]);
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_dir <= RST_PIN_IO[3:0];
			pin_level <= RST_PIN_IO[11:8];
		end else if (sw_reset) begin
			pin_dir <= nv_pin_io_in[3:0];
			pin_level <= nv_pin_io_in[11:8];
		end else if (wr && addr == ADDR_PIN_IO)
			pin_dir <= wdata[3:0];
		else if (wr && addr == (ADDR_PIN_IO | 7'h01))
			pin_level <= wdata[3:0];
	end

	// test bits: a host write that sets a bit wins over a done in the same cycle
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			misc_control <= RST_MISC[11:0];
		else if (sw_reset)
			misc_control <= nv_misc_in[11:0];
		else begin
			if (wr && addr == ADDR_MISC)
				misc_control[7:0] <= wdata;
			if (wr && addr == (ADDR_MISC | 7'h01))
				misc_control[11:8] <= wdata[3:0];
			else begin
				if (mem_test_done_in)
					misc_control[MISC_MEM_TEST_BIT] <= 1'b0;
				if (self_test_done_in)
					misc_control[MISC_SELF_TEST_BIT] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// sleep control
	// ************************************************************
	logic cs_n_q;
	logic cs_fall;
	logic [24:0] unit_cnt;
	logic [7:0] units_left;
	assign cs_fall = cs_n_q & ~cs_n_in;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cs_n_q <= 1'b1;
		else
			cs_n_q <= cs_n_in;
	end

	// registers are untouched while asleep, so waking resumes as configured
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= SSC_RUN;
			sleep_control <= 9'h000;
			unit_cnt <= 25'h0;
			units_left <= 8'h00;
		end else if (sw_reset) begin
			state <= SSC_RUN;
			sleep_control <= 9'h000;
		end else begin
			case (state)
			SSC_RUN: begin
				unit_cnt <= 25'h0;
				if (wr && addr == (ADDR_SLEEP | 7'h01) && wdata[0]) begin
					sleep_control[8] <= 1'b1;
					state <= SSC_SLEEP_INDEF;
				end else if (wr && addr == ADDR_SLEEP) begin
					sleep_control[7:0] <= wdata;
					units_left <= wdata;
					if (wdata != 8'h00)
						state <= SSC_SLEEP_TIMED;
				end
			end
			SSC_SLEEP_INDEF: begin
				if (cs_fall) begin
					sleep_control[8] <= 1'b0;
					state <= SSC_RUN;
				end
			end
			SSC_SLEEP_TIMED: begin
				if (unit_cnt == HALF_M1) begin
					unit_cnt <= 25'h0;
					units_left <= units_left - 8'h01;
					if (units_left == 8'h01)
						state <= SSC_RUN;
				end else
					unit_cnt <= unit_cnt + 25'h1;
			end
			default: state <= SSC_RUN;
			endcase
		end
	end

	// ************************************************************
	// sample timing
	// ************************************************************
	logic running;
	logic ext_mode;
	logic io4_q;
	logic [19:0] base_cnt;
	logic [6:0] inc_cnt;
	logic base_tick;
	logic tick;
	assign running = state == SSC_RUN;
	assign ext_mode = sample_period == 8'h00 && !pin_dir[3];
	// >= so a period write never strands a counter beyond its new end
	assign base_tick = base_cnt >= (sample_period[SP_TIMEBASE_BIT] ? SLOW_M1 : FAST_M1);
	assign tick = running && (ext_mode ? (io_in[3] & ~io4_q) : (base_tick && inc_cnt >= sample_period[6:0]));

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io4_q <= 1'b0;
			base_cnt <= 20'h0;
			inc_cnt <= 7'h0;
		end else begin
			io4_q <= io_in[3];
			if (sw_reset || !running || ext_mode) begin
				base_cnt <= 20'h0;
				inc_cnt <= 7'h0;
			end else if (base_tick) begin
				base_cnt <= 20'h0;
				inc_cnt <= (inc_cnt >= sample_period[6:0]) ? 7'h0 : inc_cnt + 7'h1;
			end else
				base_cnt <= base_cnt + 20'h1;
		end
	end

	// ************************************************************
	// two cascaded averaging stages
	// ************************************************************
	// a tap change restarts the window fill so the running sums stay exact
	logic [2:0] taps_q;
	logic [6:0] wr_ptr;
	logic [7:0] fill;
	logic [7:0] n_taps;
	logic [DATA_W-1:0] stage_out [0:1];
	assign n_taps = 8'h01 << taps;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			taps_q <= RST_FILTER_RANGE[2:0];
			wr_ptr <= 7'h0;
			fill <= 8'h00;
		end else begin
			taps_q <= taps;
			if (taps != taps_q)
				fill <= 8'h00;
			else if (tick) begin
				wr_ptr <= wr_ptr + 7'h1;
				if (fill < n_taps)
					fill <= fill + 8'h01;
			end
		end
	end

	for (genvar s = 0; s < 2; s++) begin : g_stage
		logic [DATA_W-1:0] hist [0:127];
		logic signed [SW-1:0] sum;
		logic [DATA_W-1:0] din;
		logic [DATA_W-1:0] old;
		assign din = (s == 0) ? sample_data_in : stage_out[0];
		assign old = (fill < n_taps) ? '0 : hist[wr_ptr - n_taps[6:0]];

		always_ff @(posedge mclk_in) begin
			if (tick)
				hist[wr_ptr] <= din;
		end

		always_ff @(posedge mclk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				sum <= '0;
				stage_out[s] <= '0;
			end else if (taps != taps_q)
				sum <= '0;
			else if (tick) begin
				sum <= sum + SW'($signed(din)) - SW'($signed(old));
				stage_out[s] <= DATA_W'((sum + SW'($signed(din)) - SW'($signed(old))) >>> taps);
			end
		end
	end

	// ************************************************************
	// data ready pulse and i/o lines
	// ************************************************************
	logic tick_q;
	logic dr_active;
	logic [15:0] dr_cnt;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_q <= 1'b0;
			dr_active <= 1'b0;
			dr_cnt <= 16'h0;
		end else begin
			tick_q <= tick;
			if (tick_q) begin
				dr_active <= 1'b1;
				dr_cnt <= 16'h1;
			end else if (dr_active && dr_cnt == PULSE_LEN)
				dr_active <= 1'b0;
			else if (dr_active)
				dr_cnt <= dr_cnt + 16'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io_out <= 4'h0;
			io_oe_n_out <= 4'hF;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (misc_control[MISC_DR_EN_BIT] && i == int'(misc_control[MISC_DR_SEL_BIT])) begin
					io_out[i] <= dr_active ~^ misc_control[MISC_DR_POL_BIT];
					io_oe_n_out[i] <= 1'b0;
				end else if (alarm_own_in[i]) begin
					io_out[i] <= alarm_level_in[i];
					io_oe_n_out[i] <= 1'b0;
				end else begin
					io_out[i] <= pin_level[i];
					io_oe_n_out[i] <= ~pin_dir[i];
				end
			end
		end
	end

	// ************************************************************
	// read-back and outputs
	// ************************************************************
	logic [3:0] level_view;
	assign level_view = (pin_dir & pin_level) | (~pin_dir & io_in);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= 16'h0;
			filtered_out <= '0;
		end else begin
			rd_valid_out <= frame_valid_in & ~frame_in[FRAME_WR_BIT];
			if (frame_valid_in && !frame_in[FRAME_WR_BIT]) begin
				case (addr & 7'h7E)
				ADDR_SAMPLE_PERIOD: rd_data_out <= {8'h00, sample_period};
				ADDR_SLEEP: rd_data_out <= {7'h00, sleep_control};
				ADDR_FILTER_RANGE: rd_data_out <= {5'h00, range, 5'h00, taps};
				ADDR_PIN_IO: rd_data_out <= {4'h0, level_view, 4'h0, pin_dir};
				ADDR_MISC: rd_data_out <= {4'h0, misc_control[11:6], 3'h0, misc_control[2:0]};
				default: rd_data_out <= 16'h0;
				endcase
			end
			if (tick_q)
				filtered_out <= stage_out[1];
		end
	end

	assign sample_tick_out = tick;
	assign mem_test_out = misc_control[MISC_MEM_TEST_BIT];
	assign self_test_out = misc_control[MISC_SELF_TEST_BIT];
	assign stim_neg_out = misc_control[9];
	assign stim_pos_out = misc_control[8];
	assign bias_comp_out = misc_control[7];
	assign origin_align_out = misc_control[6];
	assign range_out = range;
	assign low_power_out = sample_period >= LOW_POWER_MIN;
	assign sleeping_out = !running;
	assign restart_out = sw_reset;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	logic [15:0] pulse_len;
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pulse_len <= 16'h0;
		else
			// restarts with the pulse, so a retriggered pulse is judged from its last start
			pulse_len <= tick_q ? 16'h1 : (dr_active ? pulse_len + 16'h1 : 16'h0);
	end

	low_power_a: assert property (wr && addr == ADDR_SAMPLE_PERIOD && wdata >= 8'h0A && !sw_reset |=> low_power_out)
		else $error("low power not entered");
	indef_wake_a: assert property (state == SSC_SLEEP_INDEF && cs_fall && !sw_reset |=> state == SSC_RUN)
		else $error("no wake on chip-select fall");
	timed_sleep_a: assert property (running && wr && addr == ADDR_SLEEP && wdata != 8'h00 && !sw_reset
		|=> state == SSC_SLEEP_TIMED ##1 !sample_tick_out)
		else $error("timed sleep not entered");
	range_floor_a: assert property (range == RANGE_MID |-> taps >= TAPS_MIN_MID)
		else $error("middle range taps too small");
	narrow_floor_a: assert property (range == RANGE_NARROW |-> taps >= TAPS_MIN_NARROW)
		else $error("narrow range taps too small");
	pulse_width_a: assert property ($fell(dr_active) |-> $past(pulse_len) == PULSE_LEN)
		else $error("data ready pulse width wrong");
	dr_polarity_a: assert property (misc_control[MISC_DR_EN_BIT] && !misc_control[MISC_DR_SEL_BIT]
		|=> !io_oe_n_out[0] && io_out[0] == ($past(dr_active) ~^ $past(misc_control[MISC_DR_POL_BIT])))
		else $error("data ready level wrong on line one");
	gpio_drive_a: assert property (!alarm_own_in[3] && pin_dir[3] |=> !io_oe_n_out[3] && io_out[3] == $past(pin_level[3]))
		else $error("line four not driven");
	self_clear_a: assert property (self_test_done_in && !(wr && addr == (ADDR_MISC | 7'h01)) && !sw_reset
		|=> !self_test_out)
		else $error("self-test bit not cleared");
	mem_clear_a: assert property (mem_test_done_in && !(wr && addr == (ADDR_MISC | 7'h01)) && !sw_reset
		|=> !mem_test_out)
		else $error("memory test bit not cleared");
	ext_tick_a: assert property (sample_tick_out && ext_mode |-> $past(io_in[3]) == 1'b0 && io_in[3])
		else $error("external tick without rising edge");

	ext_sample_c: cover property (ext_mode && sample_tick_out);
	timed_wake_c: cover property (state == SSC_SLEEP_TIMED ##1 state == SSC_RUN);
	indef_wake_c: cover property (state == SSC_SLEEP_INDEF ##1 state == SSC_RUN);
	line_two_c: cover property (misc_control[MISC_DR_SEL_BIT] && $rose(dr_active));

endmodule // ssc_core

// ### testbench/ssc_host_model.sv
// host side model: issues register frames and drives chip select
module ssc_host_model (
	// clock
	input wire logic mclk_in,
	// frames to the block
	output logic frame_valid_out,
	output logic [15:0] frame_out,
	output logic cs_n_out,
	// read answers
	input wire logic rd_valid_in,
	input wire logic [15:0] rd_data_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		frame_valid_out = 1'b0;
		frame_out = 16'h0000;
		cs_n_out = 1'b1;
	end

	// an idle edge before each frame keeps valid from being set twice in one step
	task automatic send(input logic [15:0] f);
		@(posedge mclk_in);
		#1;
		frame_out = f;
		frame_valid_out = 1'b1;
		@(posedge mclk_in);
		#1;
		frame_valid_out = 1'b0;
		// a released bus shows a changed pattern, not the last frame
		frame_out = ~f;
	endtask

	task automatic write_byte(input logic [6:0] addr, input logic [7:0] data);
		send({1'b1, addr, data});
	endtask

	task automatic read_word(input logic [6:0] addr, output logic [15:0] data, output bit ok);
		int i;
		ok = 1'b0;
		data = 16'hXXXX;
		send({1'b0, addr, 8'h00});
		for (i = 0; i < 4 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				data = rd_data_in;
				ok = 1'b1;
			end else begin
				@(posedge mclk_in);
				#1;
			end
		end
	endtask

	// a high-to-low chip select is what ends indefinite sleep
	task automatic wake();
		@(posedge mclk_in);
		#1;
		cs_n_out = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		cs_n_out = 1'b1;
	endtask
endmodule // ssc_host_model

// ### testbench/ssc_core_test.sv
// self-checking bench for the sample and i/o control block
module ssc_core_test
	import ssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// short counts keep the run brief
	localparam int FAST = 8;
	localparam int SLOW = 20;
	localparam int HALF = 10;
	localparam int PULSE = 5;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic fv, cs_n, rd_valid, tick, mem_done = 1'b0, self_done = 1'b0;
	logic [15:0] frame, rd_data, filtered, sample_data = 16'h0000;
	logic [15:0] nv_sp = 16'h0003, nv_fr = 16'h0201, nv_pin = 16'h0000, nv_misc = 16'h0006;
	logic [3:0] alarm_own = 4'h0, alarm_level = 4'h0, io_drv = 4'h0, io_in, io_out, io_oe_n;
	logic mem_test, self_test, stim_neg, stim_pos, bias, origin, low_power, sleeping, restart;
	logic [2:0] range;
	int fail_count = 0, tests_run = 0, cyc = 0, ticks = 0, gap = 0, last_tick = 0, restarts = 0;

	always #12.5 mclk = ~mclk;
	// wire level: the block's drive where enabled, else the bench's
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & io_drv);

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (restart === 1'b1) restarts <= restarts + 1;
		if (tick === 1'b1) begin
			ticks <= ticks + 1;
			gap <= cyc - last_tick;
			last_tick <= cyc;
		end
	end

	ssc_host_model i_ssc_host_model (.mclk_in(mclk), .frame_valid_out(fv), .frame_out(frame),
		.cs_n_out(cs_n), .rd_valid_in(rd_valid), .rd_data_in(rd_data));

	ssc_core #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW), .HALF_SEC_CYCLES(HALF), .PULSE_CYCLES(PULSE)) i_ssc_core (
		.mclk_in(mclk), .rst_n_in(rst_n), .frame_valid_in(fv), .frame_in(frame), .cs_n_in(cs_n),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data), .nv_sample_period_in(nv_sp),
		.nv_filter_range_in(nv_fr), .nv_pin_io_in(nv_pin), .nv_misc_in(nv_misc),
		.sample_data_in(sample_data), .sample_tick_out(tick), .filtered_out(filtered),
		.alarm_own_in(alarm_own), .alarm_level_in(alarm_level), .io_in(io_in), .io_out(io_out),
		.io_oe_n_out(io_oe_n), .mem_test_done_in(mem_done), .self_test_done_in(self_done),
		.mem_test_out(mem_test), .self_test_out(self_test), .stim_neg_out(stim_neg),
		.stim_pos_out(stim_pos), .bias_comp_out(bias), .origin_align_out(origin), .range_out(range),
		.low_power_out(low_power), .sleeping_out(sleeping), .restart_out(restart));

	// ************************************************************
	// shared helpers
	// ************************************************************
	task automatic results();
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_up(input string what);
		fail_count++;
		$display("ERROR %s expected done seen timeout", what);
		results();
	endtask

	task automatic step();
		@(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		i_ssc_host_model.write_byte(addr, data);
	endtask

	task automatic rd(input logic [6:0] addr, input logic [15:0] exp, input string what);
		logic [15:0] d;
		bit ok;
		i_ssc_host_model.read_word(addr, d, ok);
		if (!ok) give_up(what);
		check(what, ok ? d : 16'hXXXX, exp);
	endtask

	task automatic wait_ticks(input int n);
		int start;
		int i;
		start = ticks;
		for (i = 0; i < 4000 && ticks < start + n; i++) step();
		if (ticks < start + n) begin
			fail_count++;
			$display("ERROR tick wait expected %0d seen %0d", n, ticks - start);
			results();
		end
	endtask

	// waits out any running pulse, then measures the next one
	task automatic pulse_len(input int ln, input logic act, output int n);
		int i;
		n = 0;
		for (i = 0; i < 100 && io_out[ln] !== ~act; i++) step();
		for (i = 0; i < 100 && io_out[ln] !== act; i++) step();
		while (io_out[ln] === act && n < 40) begin
			step();
			n++;
		end
		if (n == 0 || n == 40) give_up("pulse wait");
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		rd(ADDR_SAMPLE_PERIOD, 16'h0001, "sample_period");
		rd(ADDR_FILTER_RANGE, 16'h0402, "filter_and_range");
		rd(ADDR_PIN_IO, 16'h0000, "pin_io_control");
		rd(ADDR_MISC, 16'h0006, "misc_control");
		rd(7'h40, 16'h0000, "unmapped");
		check("range_out", {13'h0, range}, 16'h0004);
		check("io_oe_n_out", {12'h0, io_oe_n}, 16'h000E);
		$display("t_reset done");
	endtask

	task automatic t_period();
		wait_ticks(3);
		check("fast gap", 16'(gap), 16'(FAST * 2));
		wr(ADDR_SAMPLE_PERIOD, 8'h80);
		wait_ticks(3);
		check("slow gap", 16'(gap), 16'(SLOW));
		wr(ADDR_SAMPLE_PERIOD, 8'h09);
		check("low power 09", {15'h0, low_power}, 16'h0000);
		wr(ADDR_SAMPLE_PERIOD, 8'h0A);
		check("low power 0A", {15'h0, low_power}, 16'h0001);
		wr(ADDR_SAMPLE_PERIOD, 8'h01);
		$display("t_period done");
	endtask

	task automatic t_sleep();
		int n;
		int t0;
		wr(ADDR_SLEEP + 7'h01, 8'h01);
		check("indef sleeping", {15'h0, sleeping}, 16'h0001);
		t0 = ticks;
		repeat (60) step();
		check("ticks in sleep", 16'(ticks - t0), 16'h0000);
		i_ssc_host_model.wake();
		repeat (2) step();
		check("woken", {15'h0, sleeping}, 16'h0000);
		rd(ADDR_SLEEP, 16'h0000, "sleep_control");
		wr(ADDR_SLEEP, 8'h03);
		n = 0;
		while (sleeping === 1'b1 && n < 200) begin
			step();
			n++;
		end
		if (sleeping !== 1'b0) give_up("timed sleep");
		check("timed sleep", 16'(n >= 3 * HALF - 1 && n <= 3 * HALF + 1), 16'h0001);
		rd(ADDR_SAMPLE_PERIOD, 16'h0001, "period after wake");
		wait_ticks(3);
		check("gap after wake", 16'(gap), 16'(FAST * 2));
		$display("t_sleep done");
	endtask

	task automatic t_range();
		wr(ADDR_FILTER_RANGE + 7'h01, 8'h02);
		rd(ADDR_FILTER_RANGE, 16'h0202, "mid range");
		wr(ADDR_FILTER_RANGE, 8'h01);
		rd(ADDR_FILTER_RANGE, 16'h0202, "mid floor");
		wr(ADDR_FILTER_RANGE + 7'h01, 8'h01);
		rd(ADDR_FILTER_RANGE, 16'h0104, "narrow floor");
		wr(ADDR_FILTER_RANGE, 8'h06);
		rd(ADDR_FILTER_RANGE, 16'h0106, "narrow taps");
		check("range_out", {13'h0, range}, 16'h0001);
		wr(ADDR_FILTER_RANGE + 7'h01, 8'h04);
		wr(ADDR_FILTER_RANGE, 8'h00);
		rd(ADDR_FILTER_RANGE, 16'h0400, "wide no floor");
		$display("t_range done");
	endtask

	task automatic t_filter();
		sample_data = 16'h0300;
		wait_ticks(3);
		check("one tap", filtered, 16'h0300);
		sample_data = 16'h0100;
		wr(ADDR_FILTER_RANGE, 8'h02);
		wait_ticks(12);
		check("settled", filtered, 16'h0100);
		sample_data = 16'h0200;
		wait_ticks(2);
		check("averaging", 16'(filtered === 16'h0200), 16'h0000);
		wait_ticks(10);
		check("resettled", filtered, 16'h0200);
		wr(ADDR_FILTER_RANGE, 8'h00);
		$display("t_filter done");
	endtask

	task automatic t_ready();
		int n;
		pulse_len(0, 1'b1, n);
		check("default pulse", 16'(n), 16'(PULSE));
		wr(ADDR_MISC, 8'h04);
		step();
		check("low pol idle", {15'h0, io_out[0]}, 16'h0001);
		pulse_len(0, 1'b0, n);
		check("low pulse", 16'(n), 16'(PULSE));
		alarm_own = 4'b0010;
		alarm_level = 4'b0010;
		wr(ADDR_MISC, 8'h07);
		pulse_len(1, 1'b1, n);
		check("line two pulse", 16'(n), 16'(PULSE));
		check("line one free", {15'h0, io_oe_n[0]}, 16'h0001);
		wr(ADDR_MISC, 8'h03);
		step();
		check("alarm level", {15'h0, io_out[1]}, 16'h0001);
		check("alarm drives", {15'h0, io_oe_n[1]}, 16'h0000);
		alarm_own = 4'h0;
		alarm_level = 4'h0;
		$display("t_ready done");
	endtask

	task automatic t_gpio();
		wr(ADDR_MISC, 8'h00);
		io_drv = 4'b0001;
		wr(ADDR_PIN_IO + 7'h01, 8'h08);
		wr(ADDR_PIN_IO, 8'h0C);
		step();
		check("directions", {12'h0, io_oe_n}, 16'h0003);
		check("levels", {12'h0, io_out & 4'hC}, 16'h0008);
		rd(ADDR_PIN_IO, 16'h090C, "pin read");
		alarm_own = 4'b1000;
		repeat (2) step();
		check("alarm over gpio", {15'h0, io_out[3]}, 16'h0000);
		alarm_own = 4'h0;
		wr(ADDR_PIN_IO, 8'h00);
		$display("t_gpio done");
	endtask

	task automatic t_ext();
		int t0;
		io_drv = 4'h0;
		wr(ADDR_SAMPLE_PERIOD, 8'h00);
		t0 = ticks;
		repeat (40) step();
		check("no edges", 16'(ticks - t0), 16'h0000);
		repeat (3) begin
			io_drv[3] = 1'b1;
			repeat (2) step();
			io_drv[3] = 1'b0;
			repeat (2) step();
		end
		check("ext ticks", 16'(ticks - t0), 16'h0003);
		wr(ADDR_SAMPLE_PERIOD, 8'h01);
		$display("t_ext done");
	endtask

	task automatic t_ctrl();
		wr(ADDR_MISC + 7'h01, 8'h0F);
		wr(ADDR_MISC, 8'hC6);
		check("ctrl set", {10'h0, mem_test, self_test, stim_neg, stim_pos, bias, origin}, 16'h003F);
		mem_done = 1'b1;
		step();
		mem_done = 1'b0;
		step();
		check("mem clear", {10'h0, mem_test, self_test, stim_neg, stim_pos, bias, origin}, 16'h001F);
		self_done = 1'b1;
		step();
		self_done = 1'b0;
		rd(ADDR_MISC, 16'h03C6, "misc after tests");
		wr(ADDR_MISC + 7'h01, 8'h00);
		$display("t_ctrl done");
	endtask

	task automatic t_swreset();
		int r0;
		wr(ADDR_SLEEP + 7'h01, 8'h01);
		r0 = restarts;
		wr(ADDR_GLOBAL_CMD, 8'h80);
		check("restart pulse", 16'(restarts - r0), 16'h0001);
		check("sleep cancel", {15'h0, sleeping}, 16'h0000);
		rd(ADDR_SAMPLE_PERIOD, 16'h0003, "reloaded period");
		rd(ADDR_FILTER_RANGE, 16'h0202, "reloaded range");
		rd(ADDR_MISC, 16'h0006, "reloaded misc");
		wait_ticks(3);
		check("reloaded gap", 16'(gap), 16'(FAST * 4));
		$display("t_swreset done");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_period();
		t_sleep();
		t_range();
		t_filter();
		t_ready();
		t_gpio();
		t_ext();
		t_ctrl();
		t_swreset();
		results();
	end
endmodule // ssc_core_test
